// ==== verilog/peepw_host.sv ====
`timescale 1ns/100ps
module peepw_host
  import peepw_pkg::*;
#(
  parameter int unsigned WINDOW_CYCLES = peepw_pkg::WINDOW_CYC,
  parameter int unsigned PROG_LIMIT_CYCLES = peepw_pkg::PROG_LIMIT_CYC
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic reqValid,
  output logic reqReady,
  input wire logic reqWrite,
  input wire logic [peepw_pkg::ADDR_W-1:0] reqAddr,
  input wire logic [peepw_pkg::DATA_W-1:0] reqData,
  output logic rspValid,
  output logic [peepw_pkg::DATA_W-1:0] rspData,
  input wire logic pollByData,
  output logic progBusy,
  output logic progDone,
  output logic progTimeout,
  output logic [peepw_pkg::ADDR_W-1:0] memAddr,
  output logic memCeN,
  output logic memOeN,
  output logic memWeN,
  input wire logic [peepw_pkg::DATA_W-1:0] memDataIn,
  output logic [peepw_pkg::DATA_W-1:0] memDataOut,
  output logic memDataOe
);
  import peepw_pkg::*;

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  logic [1:0] rstSyncQ; // Reset release pipeline
  logic rstN; // Synchronised reset for the whole block
  peepw_state_e stateQ; // Access sequencer
  logic [PHASE_W-1:0] phaseQ; // Cycles left in the current phase
  logic isPollQ; // Current read is a completion poll
  logic wasWriteQ; // Recovery follows a write
  logic pageOpenQ; // Bytes loaded, window still running
  logic [PAGE_W-1:0] pageAddrQ; // Page of the open load
  logic [CNT_W-1:0] pageCntQ; // Bytes in the open load
  logic progQ; // Device assumed programming
  logic havePrevQ; // A toggle sample is held
  logic prevToggleQ; // Previous toggle bit sample
  logic [ADDR_W-1:0] lastAddrQ; // Last byte written, for data polling
  logic [DATA_W-1:0] lastDataQ;
  logic weStart; // Write strobe pin falls two edges later
  logic readEnd; // Last cycle of a read access
  logic samePage; // Request lies in the open page
  logic [TIMER_W-1:0] winRemain; // Load window left
  logic winExpired; // Window ran out, programming begins
  logic progExpired; // Programming took too long
  logic pollDone; // Poll shows completion
  logic [DATA_W-1:0] pollSample;

  // --------------------------------------------------------------------------
  // Reset release
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      rstSyncQ <= 2'h0;
    else
      rstSyncQ <= {rstSyncQ[0], 1'b1};
  end
  assign rstN = rstSyncQ[1];

  // --------------------------------------------------------------------------
  // Acceptance
  // --------------------------------------------------------------------------
  // Any write may open a page; later ones must fit the open page,
  // arrive early enough in the window and not overfill it
  assign samePage = reqAddr[ADDR_W-1:PAGE_LSB] == pageAddrQ;
  always_comb
  begin
    reqReady = 1'b0;
    if (rstN && stateQ == PEEPW_IDLE && !progQ)
    begin
      if (!pageOpenQ)
        reqReady = 1'b1;
      else
        // Reads of this part wait out the load; loads must fit the page
        reqReady = reqWrite && samePage && (pageCntQ < CNT_W'(PAGE_BYTES))
          && (winRemain > TIMER_W'(WINDOW_GUARD));
    end
  end

  // --------------------------------------------------------------------------
  // Access sequencer
  // --------------------------------------------------------------------------
  // Polls go first; one whole access runs before the next is looked at
  always_ff @(posedge core_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      stateQ <= PEEPW_IDLE;
      phaseQ <= '0;
      isPollQ <= 1'b0;
      wasWriteQ <= 1'b0;
      memAddr <= '0;
      memDataOut <= '0;
    end
    else
    begin
      unique case (stateQ)
        PEEPW_IDLE:
        begin
          if (progQ && !progExpired)
          begin
            // Poll the last written byte
            stateQ <= PEEPW_RD_SETUP;
            memAddr <= lastAddrQ;
            isPollQ <= 1'b1;
            phaseQ <= PHASE_W'(RECOVER_CYC);
          end
          else if (reqValid && reqReady)
          begin
            memAddr <= reqAddr;
            memDataOut <= reqData;
            isPollQ <= 1'b0;
            phaseQ <= PHASE_W'(RECOVER_CYC);
            stateQ <= reqWrite ? PEEPW_WR_SETUP : PEEPW_RD_SETUP;
          end
        end
        PEEPW_RD_SETUP:
          // Select settles before the output strobe
          if (phaseQ == PHASE_W'(1))
          begin
            stateQ <= PEEPW_RD_ACCESS;
            phaseQ <= PHASE_W'(ACCESS_CYC);
          end
          else
            phaseQ <= phaseQ - PHASE_W'(1);
        PEEPW_RD_ACCESS:
          if (readEnd)
          begin
            stateQ <= PEEPW_RECOVER;
            wasWriteQ <= 1'b0;
            phaseQ <= PHASE_W'(RECOVER_CYC);
          end
          else
            phaseQ <= phaseQ - PHASE_W'(1);
        PEEPW_WR_SETUP:
          // Address and data settle before the write strobe falls
          if (weStart)
          begin
            stateQ <= PEEPW_WR_PULSE;
            phaseQ <= PHASE_W'(STROBE_CYC);
          end
          else
            phaseQ <= phaseQ - PHASE_W'(1);
        PEEPW_WR_PULSE:
          if (phaseQ == PHASE_W'(1))
          begin
            stateQ <= PEEPW_RECOVER;
            wasWriteQ <= 1'b1;
            phaseQ <= PHASE_W'(RECOVER_CYC);
          end
          else
            phaseQ <= phaseQ - PHASE_W'(1);
        PEEPW_RECOVER:
          // All strobes high; gives the standby gap between accesses
          if (phaseQ == PHASE_W'(1))
            stateQ <= PEEPW_IDLE;
          else
            phaseQ <= phaseQ - PHASE_W'(1);
      endcase
    end
  end

  assign weStart = (stateQ == PEEPW_WR_SETUP) && (phaseQ == PHASE_W'(1));
  assign readEnd = (stateQ == PEEPW_RD_ACCESS) && (phaseQ == PHASE_W'(1));

  // --------------------------------------------------------------------------
  // Pin strobes, registered one cycle behind the state
  // --------------------------------------------------------------------------
  // Write and output strobes are never low together, so the part never
  // drives against us and never mistakes a read for a write
  always_ff @(posedge core_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      memCeN <= 1'b1;
      memOeN <= 1'b1;
      memWeN <= 1'b1;
      memDataOe <= 1'b0;
    end
    else
    begin
      memCeN <= !(stateQ inside {PEEPW_RD_SETUP, PEEPW_RD_ACCESS,
        PEEPW_WR_SETUP, PEEPW_WR_PULSE});
      memOeN <= !(stateQ == PEEPW_RD_ACCESS && !readEnd);
      // Select falls in write setup, ahead of the write strobe, so the write strobe is the later edge
      memWeN <= !(stateQ == PEEPW_WR_PULSE);
      // Data held through the first recovery cycle, past the rising strobe
      memDataOe <= (stateQ inside {PEEPW_WR_SETUP, PEEPW_WR_PULSE})
        || (stateQ == PEEPW_RECOVER && wasWriteQ
        && phaseQ == PHASE_W'(RECOVER_CYC));
    end
  end

  // --------------------------------------------------------------------------
  // Read data to the user
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      rspValid <= 1'b0;
      rspData <= '0;
    end
    else
    begin
      rspValid <= readEnd && !isPollQ;
      if (readEnd && !isPollQ)
        rspData <= memDataIn;
    end
  end

  // --------------------------------------------------------------------------
  // Page load tracking
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      pageOpenQ <= 1'b0;
      pageAddrQ <= '0;
      pageCntQ <= '0;
      lastAddrQ <= '0;
      lastDataQ <= '0;
    end
    else if (weStart)
    begin
      pageOpenQ <= 1'b1;
      pageAddrQ <= memAddr[ADDR_W-1:PAGE_LSB];
      pageCntQ <= pageOpenQ ? pageCntQ + CNT_W'(1) : CNT_W'(1);
      lastAddrQ <= memAddr;
      lastDataQ <= memDataOut;
    end
    else if (winExpired)
      pageOpenQ <= 1'b0;
  end

  // Window restarts at each write start, two edges before the write strobe falls
  peepw_timer #(
    .W(TIMER_W),
    .LIMIT(WINDOW_CYCLES)
  ) uWindow (
    .clk(core_clk),
    .rstN(rstN),
    .start(weStart),
    .cancel(1'b0),
    .remaining(winRemain),
    .expired(winExpired)
  );

  // --------------------------------------------------------------------------
  // Completion polling
  // --------------------------------------------------------------------------
  // The programming time is only typical, so completion is read back
  // from the part rather than waited out; a long timer guards a dead part
  assign pollSample = memDataIn;
  assign pollDone = readEnd && isPollQ && (pollByData
    ? (pollSample[DATA_POLL_BIT] == lastDataQ[DATA_POLL_BIT])
    : (havePrevQ && pollSample[TOGGLE_BIT] == prevToggleQ));

  always_ff @(posedge core_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      progQ <= 1'b0;
      havePrevQ <= 1'b0;
      prevToggleQ <= 1'b0;
      progDone <= 1'b0;
      progTimeout <= 1'b0;
    end
    else
    begin
      progDone <= pollDone;
      progTimeout <= progExpired && progQ;
      if (winExpired)
      begin
        progQ <= 1'b1;
        havePrevQ <= 1'b0;
      end
      else if (pollDone || progExpired)
      begin
        progQ <= 1'b0;
        havePrevQ <= 1'b0;
      end
      else if (readEnd && isPollQ)
      begin
        havePrevQ <= 1'b1;
        prevToggleQ <= pollSample[TOGGLE_BIT];
      end
    end
  end

  peepw_timer #(
    .W(TIMER_W),
    .LIMIT(PROG_LIMIT_CYCLES)
  ) uProgLimit (
    .clk(core_clk),
    .rstN(rstN),
    .start(winExpired),
    .cancel(pollDone),
    .remaining(),
    .expired(progExpired)
  );

  assign progBusy = progQ || pageOpenQ;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  a_read_strobes: assert property (@(posedge core_clk) disable iff (!rstN)
    !memOeN |-> !memCeN && memWeN) else $error("output strobe without select");
  a_write_strobes: assert property (@(posedge core_clk) disable iff (!rstN)
    !memWeN |-> !memCeN && memOeN) else $error("write strobe misqualified");
  a_no_contention: assert property (@(posedge core_clk) disable iff (!rstN)
    memDataOe |-> memOeN) else $error("driving data while part may drive");
  a_page_address: assert property (@(posedge core_clk) disable iff (!rstN)
    $fell(memWeN) && $past(pageOpenQ, 2) |-> memAddr[ADDR_W-1:PAGE_LSB] == $past(pageAddrQ, 2))
    else $error("page load left its page");
  a_byte_limit: assert property (@(posedge core_clk) disable iff (!rstN)
    $fell(memWeN) |-> pageCntQ <= CNT_W'(PAGE_BYTES) && pageCntQ != '0)
    else $error("page load byte count out of range");
  a_load_window: assert property (@(posedge core_clk) disable iff (!rstN)
    $fell(memWeN) && $past(pageOpenQ, 2) |-> $past(winRemain, 2) > TIMER_W'(1))
    else $error("byte load after window closed");
  a_prog_no_write: assert property (@(posedge core_clk) disable iff (!rstN)
    progQ |-> !weStart && !reqReady) else $error("write while programming");
  a_prog_after_window: assert property (@(posedge core_clk) disable iff (!rstN)
    winExpired |=> progQ && !pageOpenQ)
    else $error("programming not assumed after window");
  a_poll_reads_last: assert property (@(posedge core_clk) disable iff (!rstN)
    readEnd && isPollQ |-> memAddr == lastAddrQ && !memOeN)
    else $error("poll read wrong address");
  a_done_releases: assert property (@(posedge core_clk) disable iff (!rstN)
    pollDone |=> !progQ && progDone)
    else $error("completion not released");

endmodule

// ==== verilog/peepw_pkg.sv ====
// ----------------------------------------------------------------------------
// Shared constants for the parallel EEPROM page-write host
// ----------------------------------------------------------------------------
package peepw_pkg;

  // --------------------------------------------------------------------------
  // Bus shape
  // --------------------------------------------------------------------------
  localparam int ADDR_W = 15; // Byte address width, 32k locations
  localparam int DATA_W = 8; // One byte per location
  localparam int PAGE_LSB = 7; // Lowest page address bit
  localparam int PAGE_W = ADDR_W - PAGE_LSB; // Page address bits 7..14
  localparam int PAGE_BYTES = 128; // Bytes one page load may hold
  localparam int CNT_W = 8; // Wide enough to hold PAGE_BYTES
  localparam int DATA_POLL_BIT = 7; // Complemented during programming
  localparam int TOGGLE_BIT = 6; // Alternates per read during programming

  // --------------------------------------------------------------------------
  // Timing, figures in their own unit, cycles derived at 200 MHz
  // --------------------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000; // Core clock period
  localparam int STROBE_NS = 100; // Least width of a strobe low phase
  localparam int ACCESS_NS = 150; // Least wait from read strobes to data
  localparam int RECOVER_NS = 50; // Least high time between accesses
  localparam int WINDOW_US = 100; // Byte load window, falling edge to falling edge
  localparam int PROG_LIMIT_US = 10000; // Give-up time for one programming cycle
  // Least times round up
  localparam int STROBE_CYC = (STROBE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ACCESS_CYC = (ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RECOVER_CYC = (RECOVER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Longest times round down; cycles per microsecond first, so the
  // product stays inside 32 bits even for the long give-up time
  localparam int WINDOW_CYC = WINDOW_US * (1000000 / CLK_PERIOD_PS);
  localparam int PROG_LIMIT_CYC = PROG_LIMIT_US * (1000000 / CLK_PERIOD_PS);
  localparam int PHASE_W = 8; // Phase counter width, holds the largest short count
  localparam int TIMER_W = 24; // Long timer width
  // Margin kept before window end so the next strobe still lands in time
  localparam int WINDOW_GUARD = RECOVER_CYC + 2;

  // --------------------------------------------------------------------------
  // Access sequencer states
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    PEEPW_IDLE,
    PEEPW_RD_SETUP,
    PEEPW_RD_ACCESS,
    PEEPW_WR_SETUP,
    PEEPW_WR_PULSE,
    PEEPW_RECOVER
  } peepw_state_e;

endpackage

// ==== verilog/peepw_timer.sv ====
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// Down counter: loads on start, pulses expired on reaching zero
// ----------------------------------------------------------------------------
module peepw_timer #(
  parameter int W = 24,
  parameter int unsigned LIMIT = 20000
) (
  input wire logic clk,
  input wire logic rstN,
  input wire logic start,
  input wire logic cancel,
  output logic [W-1:0] remaining,
  output logic expired
);

  logic [W-1:0] cntQ; // Cycles left, zero when idle

  // --------------------------------------------------------------------------
  // Count down
  // --------------------------------------------------------------------------
  // Start beats cancel so a restart in the same cycle is not lost
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      cntQ <= '0;
    else if (start)
      cntQ <= W'(LIMIT);
    else if (cancel)
      cntQ <= '0;
    else if (cntQ != '0)
      cntQ <= cntQ - W'(1);
  end

  assign remaining = cntQ;
  // One-cycle pulse on the last count
  assign expired = (cntQ == W'(1)) && !start && !cancel;

endmodule

// ==== tb/peepw_eeprom_model.sv ====
`timescale 1ns/100ps
// --------------------------------------------------------------
// Behavioural byte-alterable memory behind the pins
// --------------------------------------------------------------
module peepw_eeprom_model
  import peepw_pkg::*;
#(
  parameter int WINDOW_NS = 1000,
  parameter int ACC_NS = 120
) (
  input wire logic [peepw_pkg::ADDR_W-1:0] memAddr,
  input wire logic memCeN,
  input wire logic memOeN,
  input wire logic memWeN,
  input wire logic [peepw_pkg::DATA_W-1:0] busLine,
  input wire logic [31:0] progNs,
  output logic [peepw_pkg::DATA_W-1:0] drvData,
  output logic drvEn,
  output int faults,
  output int commits
);
  logic [DATA_W-1:0] mem [0:32767];
  logic [DATA_W-1:0] page [0:127]; // Bytes loaded, not yet burnt
  logic [127:0] ldMask = '0;
  logic [ADDR_W-1:0] wrAddr;
  logic [DATA_W-1:0] lastData;
  logic [PAGE_W-1:0] pageId;
  logic busy = 1'b0;
  logic tog = 1'b0;
  logic taking = 1'b0;
  int nLoad = 0;
  int loadSeq = 0;
  int rdSeq = 0;
  wire rdAct = !memCeN && !memOeN;
  wire wrAct = !memCeN && !memWeN && memOeN;

  initial
  begin
    drvData = 8'h00;
    drvEn = 1'b0;
    faults = 0;
    commits = 0;
  end

  // Self-timed burn of every loaded byte
  task automatic burn();
    busy = 1'b1;
    #(progNs);
    for (int i = 0; i < PAGE_BYTES; i++)
      if (ldMask[i]) mem[{pageId, 7'(i)}] = page[i];
    commits += nLoad;
    nLoad = 0;
    ldMask = '0;
    busy = 1'b0;
  endtask

  // Only the latest load may start the burn
  task automatic arm(input int s);
    #(WINDOW_NS);
    if (s == loadSeq && !busy) burn();
  endtask

  // Data is garbage until the access time has passed
  task automatic fill(input int s);
    #(ACC_NS);
    if (s == rdSeq && rdAct)
      drvData = busy ? {~lastData[7], tog, lastData[5:0]} : mem[memAddr];
  endtask

  // Address at the later falling strobe; ignored while burning
  always @(posedge wrAct)
  begin
    taking = !busy;
    if (taking)
    begin
      if (nLoad > 0 && memAddr[14:7] != pageId) faults++;
      if (nLoad >= PAGE_BYTES) faults++;
      if (nLoad == 0) pageId = memAddr[14:7];
      wrAddr = memAddr;
      loadSeq++;
      fork
        arm(loadSeq);
      join_none
    end
  end

  // Data at the earlier rising strobe
  always @(negedge wrAct)
  if (taking)
  begin
    page[wrAddr[6:0]] = busLine;
    if (!ldMask[wrAddr[6:0]]) nLoad++;
    ldMask[wrAddr[6:0]] = 1'b1;
    lastData = busLine;
    taking = 1'b0;
  end

  // Read start flips the status bit while burning
  always @(posedge rdAct)
  begin
    rdSeq++;
    if (busy) tog = ~tog;
    drvEn = 1'b1;
    drvData = ~drvData;
    fork
      fill(rdSeq);
    join_none
  end

  // Released bus shows the inverse, not a held value
  always @(negedge rdAct)
  begin
    rdSeq++;
    drvEn = 1'b0;
    drvData = ~drvData;
  end
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/100ps
// --------------------------------------------------------------
// Self-checking bench for the page-write host
// --------------------------------------------------------------
module tb_top;
  import peepw_pkg::*;
  localparam int WIN_CYC = 200; // Short byte-load window
  localparam int LIM_CYC = 5000; // Short give-up time
  typedef struct packed {
    logic poll;
    logic [ADDR_W-1:0] a;
    logic [DATA_W-1:0] d;
    logic [DATA_W-1:0] x;
  } peepw_row_s;
  logic core_clk, rst_n, reqValid, reqWrite, pollByData;
  logic [ADDR_W-1:0] reqAddr, memAddr;
  logic [DATA_W-1:0] reqData, rspData, memDataOut, drvData, got;
  logic reqReady, rspValid, progBusy, progDone, progTimeout;
  logic memCeN, memOeN, memWeN, memDataOe, drvEn;
  logic [31:0] progNs;
  int faults, commits, n_mismatch, n_compared, nDone, nTmo, seen, k, c0;
  wire [DATA_W-1:0] busLine = memDataOe ? memDataOut : drvData;
  // Ordinary single-byte writes, both completion methods
  peepw_row_s rows [4] = '{'{1'b1, 15'h0000, 8'h5A, 8'h5A}, '{1'b0, 15'h7FFF, 8'hA5, 8'hA5},
    '{1'b1, 15'h0155, 8'hC3, 8'hC3}, '{1'b0, 15'h2AAA, 8'h3C, 8'h3C}};

  peepw_host #(.WINDOW_CYCLES(WIN_CYC), .PROG_LIMIT_CYCLES(LIM_CYC)) dut (.core_clk, .rst_n,
    .reqValid, .reqReady, .reqWrite, .reqAddr, .reqData, .rspValid, .rspData, .pollByData,
    .progBusy, .progDone, .progTimeout, .memAddr, .memCeN, .memOeN, .memWeN,
    .memDataIn(busLine), .memDataOut, .memDataOe);
  peepw_eeprom_model #(.WINDOW_NS(WIN_CYC * 5)) farMem (.memAddr, .memCeN, .memOeN,
    .memWeN, .busLine, .progNs, .drvData, .drvEn, .faults, .commits);

  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // Count completion pulses so none is missed
  always @(posedge core_clk)
  begin
    if (progDone === 1'b1) nDone++;
    if (progTimeout === 1'b1) nTmo++;
  end

  // Pin hygiene every cycle
  always @(negedge core_clk)
  if (rst_n === 1'b1)
  begin
    chk1(memDataOe & drvEn, 1'b0, "bus fight");
    chk1(!memOeN & !memWeN, 1'b0, "strobe overlap");
  end

  task automatic chk1(input logic g, input logic e, input string m);
    n_compared++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD %0t %s", $time, m);
    end
  endtask

  task automatic chk8(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e, input string m);
    n_compared++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD %0t %s %h %h", $time, m, g, e);
    end
  endtask

  task automatic end_sim();
    if (n_mismatch == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Request held until taken; k counts refused cycles
  task automatic send(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge core_clk);
    #1;
    reqValid = 1'b1;
    reqWrite = w;
    reqAddr = a;
    reqData = d;
    k = 0;
    @(negedge core_clk);
    while (reqReady !== 1'b1 && k < 9000)
    begin
      @(negedge core_clk);
      k++;
    end
    chk1(k < 9000, 1'b1, "request never taken");
    @(posedge core_clk);
    #1;
    reqValid = 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a);
    send(1'b0, a, 8'h00);
    k = 0;
    while (rspValid !== 1'b1 && k < 200)
    begin
      @(negedge core_clk);
      k++;
    end
    chk1(rspValid, 1'b1, "no read answer");
    got = rspData;
  endtask

  // Wait for the next completion or give-up pulse
  task automatic settle();
    k = 0;
    while (nDone + nTmo == seen && k < 9000)
    begin
      @(negedge core_clk);
      k++;
    end
    chk1(k < 9000, 1'b1, "no completion");
    seen = nDone + nTmo;
  endtask

  initial
  begin
    rst_n = 1'b0;
    reqValid = 1'b0;
    reqWrite = 1'b0;
    reqAddr = '0;
    reqData = '0;
    pollByData = 1'b1;
    progNs = 32'd3000;
    repeat (3) @(posedge core_clk);
    #1;
    chk1(memCeN & memOeN & memWeN & !memDataOe, 1'b1, "reset pins");
    rst_n = 1'b1;
    @(negedge core_clk);
    chk1(reqReady, 1'b0, "ready in reset");
    foreach (rows[i])
    begin
      @(posedge core_clk);
      #1;
      pollByData = rows[i].poll;
      send(1'b1, rows[i].a, rows[i].d);
      repeat (WIN_CYC + 45) @(negedge core_clk);
      chk1(progBusy & !reqReady, 1'b1, "not busy while burning");
      chk1(nDone == seen, 1'b1, "early completion");
      settle();
      chk1(nTmo == 0, 1'b1, "gave up");
      rd(rows[i].a);
      chk8(got, rows[i].x, "readback");
    end
    // Short page, then a write to another page must wait for the burn
    // Idle gaps stand for accesses elsewhere; still inside the window
    for (int i = 0; i < 3; i++)
    begin
      send(1'b1, 15'h1280 + 15'(i), 8'h90 + 8'(i));
      repeat (60) @(negedge core_clk);
    end
    send(1'b1, 15'h2000, 8'h77);
    chk1(k >= WIN_CYC, 1'b1, "other page taken early");
    chk1(nDone == seen + 1, 1'b1, "page not burnt first");
    settle();
    settle();
    for (int i = 0; i < 3; i++)
    begin
      rd(15'h1280 + 15'(i));
      chk8(got, 8'h90 + 8'(i), "page byte");
    end
    rd(15'h2000);
    chk8(got, 8'h77, "after burn");
    // Full page of the largest size
    c0 = commits;
    for (int i = 0; i < PAGE_BYTES; i++)
      send(1'b1, 15'h4000 + 15'(i), 8'(i) ^ 8'h3C);
    settle();
    chk1(commits == c0 + PAGE_BYTES, 1'b1, "page size");
    rd(15'h4000);
    chk8(got, 8'h3C, "first of page");
    rd(15'h407F);
    chk8(got, 8'h43, "last of page");
    chk1(faults == 0, 1'b1, "page rules broken");
    // Burn slower than the give-up time
    progNs = 32'd30000;
    send(1'b1, 15'h0300, 8'h11);
    settle();
    chk1(nTmo == 1, 1'b1, "no give-up");
    end_sim();
  end

  // Tests need about 20k cycles; this is four times that
  initial
  begin
    #400000;
    n_mismatch++;
    end_sim();
  end
endmodule
